// ---- chan0_config_cal_regs.sv ----
// Purpose: Channel 0 configuration and calibration register bank
// Assumes: Avalon-MM slave with waitrequest, byte addressing, word index from address bits 6:2
// Notes: Control outputs feed filter, phase and calibration datapaths
`timescale 1ns/100ps
module chan0_config_cal_regs (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output chan0_regs_pkg::chan0_ctrl_t ctrl
);

  localparam int NUM_REGS = 7;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_DONE = 2'h1
  } bus_state_t;

  bus_state_t state_reg;
  bus_state_t state_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] resp_reg;
  logic [1:0] resp_next;
  logic wait_reg;
  logic wait_next;
  chan0_regs_pkg::chan0_ctrl_t ctrl_reg;
  chan0_regs_pkg::chan0_ctrl_t ctrl_next;

  logic [4:0] word_idx;
  logic [3:0] dec;
  logic hit;
  logic [2:0] slot;
  logic do_write;
  logic [15:0] wr_word;
  logic [NUM_REGS-1:0] wr_sel;
  logic [15:0] regval [NUM_REGS];

  // Index of a register word to slot number, or none
  function automatic logic [3:0] decode(input logic [4:0] idx);
    case (idx)
      chan0_regs_pkg::IDX_THRESH_HIGH: decode = 4'h0;
      chan0_regs_pkg::IDX_THRESH_LOW: decode = 4'h1;
      chan0_regs_pkg::IDX_CHAN0_CFG: decode = 4'h2;
      chan0_regs_pkg::IDX_OCAL_HIGH: decode = 4'h3;
      chan0_regs_pkg::IDX_OCAL_LOW: decode = 4'h4;
      chan0_regs_pkg::IDX_GCAL_HIGH: decode = 4'h5;
      chan0_regs_pkg::IDX_GCAL_LOW: decode = 4'h6;
      default: decode = 4'h8;
    endcase
  endfunction

  localparam logic [15:0] RESETS [NUM_REGS] = '{
    chan0_regs_pkg::RST_THRESH_HIGH,
    chan0_regs_pkg::RST_THRESH_LOW,
    chan0_regs_pkg::RST_CHAN0_CFG,
    chan0_regs_pkg::RST_OCAL_HIGH,
    chan0_regs_pkg::RST_OCAL_LOW,
    chan0_regs_pkg::RST_GCAL_HIGH,
    chan0_regs_pkg::RST_GCAL_LOW
  };

  // Reserved bits are masked; writes cannot set them, they keep their zero reset value
  localparam logic [15:0] MASKS [NUM_REGS] = '{
    chan0_regs_pkg::MASK_FULL,
    chan0_regs_pkg::MASK_THRESH_LOW,
    chan0_regs_pkg::MASK_CHAN0_CFG,
    chan0_regs_pkg::MASK_FULL,
    chan0_regs_pkg::MASK_CAL_LOW,
    chan0_regs_pkg::MASK_FULL,
    chan0_regs_pkg::MASK_CAL_LOW
  };

  assign word_idx = avs_address[6:2];
  assign dec = decode(word_idx);
  assign hit = ~dec[3];
  assign slot = dec[2:0];
  // Store at the answer edge, where the master sees waitrequest low
  assign do_write = avs_write && (state_reg == BUS_DONE) && hit;

  // Byte lanes 0 and 1 merge with the stored word
  always_comb begin
    wr_word = regval[slot];
    if (avs_byteenable[0]) begin
      wr_word[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1]) begin
      wr_word[15:8] = avs_writedata[15:8];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_regs
      assign wr_sel[g] = do_write && (slot == 3'(g));
      reg_word #(
        .RESET_VALUE(RESETS[g]),
        .WRITE_MASK(MASKS[g])
      ) u_word (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .wr_en(wr_sel[g]),
        .wr_data(wr_word),
        .value(regval[g])
      );
    end
  endgenerate

  // Bus handshake: one wait cycle, then answer
  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    resp_next = resp_reg;
    wait_next = wait_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = BUS_DONE;
          wait_next = 1'b0;
          resp_next = hit ? 2'h0 : 2'h3;
          rdata_next = 32'h0000_0000;
          if (avs_read && hit) begin
            rdata_next = {16'h0000, regval[slot]};
          end
        end
      end
      BUS_DONE: begin
        state_next = BUS_IDLE;
        wait_next = 1'b1;
      end
      default: begin
        state_next = BUS_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
      wait_reg <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
      wait_reg <= wait_next;
    end
  end

  // Control word decoded from the stored registers
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.detect_threshold = {regval[0],
      regval[1][chan0_regs_pkg::THRESH_LOW_POS +: 8]};
    ctrl_next.dc_filter_coeff_sel =
      regval[1][chan0_regs_pkg::DC_SEL_POS +: 4];
    ctrl_next.dc_filter_on =
      (ctrl_next.dc_filter_coeff_sel != chan0_regs_pkg::DC_SEL_BYPASS) &&
      !regval[2][chan0_regs_pkg::DC_OFF_POS];
    // coefficient as right shift n plus one
    ctrl_next.dc_shift = {1'b0, ctrl_next.dc_filter_coeff_sel} + 5'h01;
    ctrl_next.chan0_phase_delay =
      regval[2][chan0_regs_pkg::PHASE_POS +: 10];
    ctrl_next.chan0_input_sel =
      chan0_regs_pkg::input_sel_t'(
        regval[2][chan0_regs_pkg::INPUT_SEL_POS +: 2]);
    ctrl_next.chan0_offset = {regval[3],
      regval[4][chan0_regs_pkg::CAL_LOW_POS +: 8]};
    ctrl_next.chan0_gain = {regval[5],
      regval[6][chan0_regs_pkg::CAL_LOW_POS +: 8]};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= '{
        detect_threshold: 24'h00_0000,
        dc_filter_on: 1'b0,
        dc_filter_coeff_sel: 4'h0,
        dc_shift: 5'h01,
        chan0_phase_delay: 10'h000,
        chan0_input_sel: chan0_regs_pkg::INPUT_EXTERNAL,
        chan0_offset: 24'h00_0000,
        chan0_gain: 24'h80_0000
      };
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign avs_response = resp_reg;
  assign ctrl = ctrl_reg;

endmodule // chan0_config_cal_regs

// ---- chan0_regs_pkg.sv ----
// Purpose: Constants and types for the channel 0 configuration registers
// Assumes: Avalon-MM slave, 32-bit data, registers in low 16 bits
// Notes: Printed offsets are word indices; byte address is four times
package chan0_regs_pkg;

  localparam logic [4:0] IDX_THRESH_HIGH = 5'h07;
  localparam logic [4:0] IDX_THRESH_LOW = 5'h08;
  localparam logic [4:0] IDX_CHAN0_CFG = 5'h09;
  localparam logic [4:0] IDX_OCAL_HIGH = 5'h0A;
  localparam logic [4:0] IDX_OCAL_LOW = 5'h0B;
  localparam logic [4:0] IDX_GCAL_HIGH = 5'h0C;
  localparam logic [4:0] IDX_GCAL_LOW = 5'h0D;

  localparam logic [15:0] RST_THRESH_HIGH = 16'h0000;
  localparam logic [15:0] RST_THRESH_LOW = 16'h0000;
  localparam logic [15:0] RST_CHAN0_CFG = 16'h0000;
  localparam logic [15:0] RST_OCAL_HIGH = 16'h0000;
  localparam logic [15:0] RST_OCAL_LOW = 16'h0000;
  localparam logic [15:0] RST_GCAL_HIGH = 16'h8000;
  localparam logic [15:0] RST_GCAL_LOW = 16'h0000;

  // Writable bit masks per register
  localparam logic [15:0] MASK_THRESH_LOW = 16'hFF0F;
  localparam logic [15:0] MASK_CHAN0_CFG = 16'hFFC7;
  localparam logic [15:0] MASK_CAL_LOW = 16'hFF00;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;

  localparam int THRESH_LOW_POS = 8;
  localparam int DC_SEL_POS = 0;
  localparam int PHASE_POS = 6;
  localparam int DC_OFF_POS = 2;
  localparam int INPUT_SEL_POS = 0;
  localparam int CAL_LOW_POS = 8;

  localparam logic [3:0] DC_SEL_BYPASS = 4'h0;
  localparam logic [1:0] BUS_LAT_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    INPUT_EXTERNAL = 2'h0,
    INPUT_SHORTED = 2'h1,
    INPUT_TEST_POS = 2'h2,
    INPUT_TEST_NEG = 2'h3
  } input_sel_t;

  typedef struct packed {
    logic [23:0] detect_threshold;
    logic dc_filter_on;
    logic [3:0] dc_filter_coeff_sel;
    logic [4:0] dc_shift;
    logic [9:0] chan0_phase_delay;
    input_sel_t chan0_input_sel;
    logic [23:0] chan0_offset;
    logic [23:0] chan0_gain;
  } chan0_ctrl_t;

endpackage

// ---- reg_word.sv ----
// Purpose: One 16-bit software register with a writable bit mask
// Assumes: Write strobe is a single cycle, clock enable gates all state
// Notes: Bits outside the mask hold their reset value and read as it
`timescale 1ns/100ps
module reg_word #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] value
);

  logic [15:0] word_reg;
  logic [15:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (clk_en && wr_en) begin
      word_next = (wr_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= RESET_VALUE;
    end else begin
      word_reg <= word_next;
    end
  end

  assign value = word_reg;

endmodule // reg_word

// ---- chan0_regs_chk.sv ----
// Purpose: Bus and control checks, channel 0 bank
// Assumes: One clock, async active low reset
// Notes: Bound to the top module
`timescale 1ns/100ps
module chan0_regs_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire chan0_regs_pkg::chan0_ctrl_t ctrl
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire logic [4:0] idx = avs_address[6:2];
  wire logic map = idx >= 5'h07 && idx <= 5'h0D;
  wire logic take = (avs_read | avs_write) & avs_waitrequest & clk_en;
  a_wait_once: assert property (take |=> !avs_waitrequest)
    else $error("no answer");
  a_wait_single: assert property (!avs_waitrequest && clk_en
    |=> avs_waitrequest) else $error("answer too long");
  a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_bad_decode: assert property (take && !map && avs_read
    |=> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read wrong");
  a_good_ok: assert property (take && map |=> avs_response == 2'h0)
    else $error("mapped response wrong");
  a_cal_low_zero: assert property (
    take && avs_read && (idx == 5'h0B || idx == 5'h0D)
    |=> avs_readdata[7:0] == 8'h00) else $error("low byte set");
  a_dc_bypass: assert property (
    ctrl.dc_filter_coeff_sel == 4'h0 |-> !ctrl.dc_filter_on)
    else $error("filter not bypassed");
  a_dc_shift: assert property (
    ctrl.dc_shift == {1'b0, ctrl.dc_filter_coeff_sel} + 5'h01)
    else $error("shift wrong");
  c_write: cover property (take && avs_write);
  c_read: cover property (take && avs_read);
  c_unmapped: cover property (take && !map);
endmodule // chan0_regs_chk

bind chan0_config_cal_regs chan0_regs_chk u_chk (.mclk(mclk),
  .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .ctrl(ctrl));

// ---- testbench.sv ----
// Purpose: Self-checking bench for channel 0 bank
// Assumes: Avalon-MM master, one wait cycle answers
// Notes: Shadow copy of registers gives expectations
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] rd;
  logic wt;
  logic [1:0] rsp;
  chan0_regs_pkg::chan0_ctrl_t ctrl;
  int err_total = 0;
  int num_checks = 0;
  logic [33:0] exp_q[$];
  logic [15:0] shd[7:13];
  logic [31:0] last_rd = 32'h0;
  always #50 mclk = ~mclk;
  chan0_config_cal_regs u_dut (.mclk(mclk), .resetn(resetn),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rd),
    .avs_waitrequest(wt), .avs_response(rsp), .ctrl(ctrl));
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_ctl(input chan0_regs_pkg::chan0_ctrl_t e);
    repeat (2) @(negedge mclk);
    num_checks++;
    if (ctrl !== e) begin
      err_total++;
      $display("[ERR] %0t exp %h got %h", $time, e, ctrl);
    end
  endtask
  function automatic chan0_regs_pkg::chan0_ctrl_t ctl_exp();
    chan0_regs_pkg::chan0_ctrl_t c;
    c.detect_threshold = {shd[7], shd[8][15:8]};
    c.dc_filter_coeff_sel = shd[8][3:0];
    c.dc_filter_on = shd[8][3:0] != 4'h0 && !shd[9][2];
    c.dc_shift = {1'b0, shd[8][3:0]} + 5'h01;
    c.chan0_phase_delay = shd[9][15:6];
    c.chan0_input_sel = chan0_regs_pkg::input_sel_t'(shd[9][1:0]);
    c.chan0_offset = {shd[10], shd[11][15:8]};
    c.chan0_gain = {shd[12], shd[13][15:8]};
    return c;
  endfunction
  task automatic bus(input logic w, input logic [4:0] i,
      input logic [15:0] d, input logic [3:0] be, input logic frz);
    int n;
    logic map;
    logic [15:0] bm;
    map = i >= 5'h07 && i <= 5'h0D;
    d &= (i == 5'h08) ? 16'hFF0F : (i == 5'h09) ? 16'hFFC7 : 16'hFFFF;
    bm = {{8{be[1]}}, {8{be[0]}}};
    bm &= (i == 5'h0B || i == 5'h0D) ? 16'hFF00 : 16'hFFFF;
    if (map && w) shd[i] = (shd[i] & ~bm) | (d & bm);
    last_rd = (map && !w) ? {16'h0000, shd[i]} : 32'h0;
    exp_q.push_back({map ? 2'h0 : 2'h3, last_rd});
    @(posedge mclk);
    avs_address <= {i, 2'h0};
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {~d, d};
    avs_byteenable <= be;
    if (frz) begin
      clk_en <= 1'b0;
      repeat (3) @(negedge mclk);
      chk_bus(34'h1, {33'h0, wt});
      @(posedge mclk);
      clk_en <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (n == 20) begin
      err_total++;
      stop_test();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if (resetn && wt === 1'b0) begin
      chk_bus(exp_q.size() != 0 ? exp_q.pop_front() : '1, {rsp, rd});
    end
  end
  initial begin
    int k;
    k = $urandom(21401);
    shd = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (k = 5; k < 16; k++) bus(0, 5'(k), 16'h0, 4'hF, 0);
    chk_ctl(ctl_exp());
    $display("test reset done");
    for (k = 0; k < 24; k++) begin
      bus(1, 5'($urandom_range(15, 5)), 16'($urandom), 4'($urandom), k[2]);
      bus(0, 5'($urandom_range(15, 5)), 16'h0, 4'hF, 0);
    end
    chk_ctl(ctl_exp());
    $display("test random done");
    for (k = 0; k < 16; k++) begin
      bus(1, 5'h08, {8'($urandom), 4'h0, 4'(k)}, 4'h3, 0);
      bus(1, 5'h09, {10'($urandom), 3'h0, 3'(k)}, 4'h3, 0);
      chk_ctl(ctl_exp());
    end
    $display("test modes done");
    @(posedge mclk);
    resetn <= 1'b0;
    shd = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    last_rd = 32'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    bus(0, 5'h0C, 16'h0, 4'hF, 0);
    chk_ctl(ctl_exp());
    $display("test second reset done");
    stop_test();
  end
endmodule // testbench
